// file: core/trxsc_state_ctrl.sv
// basic-mode state controller of the transceiver
//
// What this block does
// [RL1] host commands and pins both change state
// [RL2] host waits while status shows pending code
// [RL3] host reads status to confirm each change
// [RL4] pin high: idle to sleep, listen to no-clock
// [RL5] pin low in no-clock returns to listen
// [RL6] reset pin clears registers except clock select and pulls
// [RL7] idle and forced idle reach idle-clock
// [RL8] plain idle waits until busy activity ends
// [RL9] forced synth ready aborts, keeps synth powered
// [RL10] forced synth ignored in power-on, sleep, no-clock
// [RL11] host lowers sleep pin before forced commands
// [RL12] power-on starts with 1MHz clock output
// [RL13] power-on reset sets every register default
// [RL14] input pulls on in power-on only
// [RL15] leaving power-on sets digital output pulls
// [RL16] host keeps pins idle before leaving power-on; the bench pulses the reset pin in power-on
// [RL17] wake interrupt disabled by default
// [RL18] host waits for clock output before access; after its second power-on reset the bench writes at once
// [RL19] idle command in power-on reaches idle-clock
// [RL20] sleep only from idle-clock; registers kept
// [RL21] fast clock output stops after 35 edges
// [RL22] slow or off clock output stops at once
// [RL23] pin low in sleep wakes; frame buffer lost
// [RL24] reset pin in sleep wakes with defaults
// [RL25] commands invalid in a state are ignored
`include "trxsc_params.svh"
`timescale 1ns/1ps
`default_nettype none

module trxsc_state_ctrl #(
	parameter int unsigned SETTLE_NS = `TRXSC_SETTLE_NS,
	parameter int unsigned SYMBOL_HZ = `TRXSC_SYMBOL_HZ
) (
	// clock and power-on reset
	input  wire logic                 clk,
	input  wire logic                 nrst,
	// pins from outside the clock domain
	input  wire logic                 sleepTxPin,
	input  wire logic                 resetPinN,
	input  wire logic                 xtalStable,
	// host command and configuration writes
	input  wire trxsc_pkg::trxsc_cmd_t cmdReq,
	input  wire trxsc_pkg::trxsc_cfg_t cfgReq,
	// radio activity
	input  wire logic                 frameDetect,
	input  wire logic                 activityDone,
	// status and events
	output var  logic [4:0]           stateStatus,
	output var  logic [2:0]           clockOutSelect,
	output var  logic                 wakeDoneIrq,
	output var  logic                 abortActivity,
	output var  logic                 frameBufClear,
	output var  logic                 idlePending,
	// pins and power
	output var  logic                 clockOut,
	output var  logic                 inputPullEn,
	output var  logic [1:0]           digOutPullDgnd,
	output var  logic [1:0]           digOutPullAgnd,
	output var  trxsc_pkg::trxsc_pwr_t pwrCtl
);

	localparam int unsigned SETTLE_CYC_RAW = (SETTLE_NS + `TRXSC_CLK_NS - 1) / `TRXSC_CLK_NS;
	localparam int unsigned SETTLE_CYC     = (SETTLE_CYC_RAW < 1) ? 1 : SETTLE_CYC_RAW;

	// ------------------------------------------------------------
	// pin synchronisers, two flops per pin; sleep pin taken as a level
	// ------------------------------------------------------------
	logic [2:0] pinMeta_q;
	logic [2:0] pinSync_q;
	logic       sleepPin;
	logic       pinRst;
	logic       xtalOk;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pinMeta_q <= 3'h2;
			pinSync_q <= 3'h2;
		end else begin
			pinMeta_q <= {xtalStable, resetPinN, sleepTxPin};
			pinSync_q <= pinMeta_q;
		end
	end

	assign sleepPin = pinSync_q[0];
	assign pinRst   = !pinSync_q[1];
	assign xtalOk   = pinSync_q[2];

	// ------------------------------------------------------------
	// command decode
	// ------------------------------------------------------------
	logic cmdIdle;
	logic cmdForceIdle;
	logic cmdForceSynth;
	logic cmdSynth;
	logic cmdListen;
	logic cmdTx;
	logic anyIdle;

	assign cmdIdle       = cmdReq.valid && (cmdReq.code == `TRXSC_CMD_IDLE);
	assign cmdForceIdle  = cmdReq.valid && (cmdReq.code == `TRXSC_CMD_FORCE_IDLE);
	assign cmdForceSynth = cmdReq.valid && (cmdReq.code == `TRXSC_CMD_FORCE_SYNTH);
	assign cmdSynth      = cmdReq.valid && (cmdReq.code == `TRXSC_CMD_SYNTH);
	assign cmdListen     = cmdReq.valid && (cmdReq.code == `TRXSC_CMD_LISTEN);
	assign cmdTx         = cmdReq.valid && (cmdReq.code == `TRXSC_CMD_TX_START);
	assign anyIdle       = cmdIdle || cmdForceIdle;

	// ------------------------------------------------------------
	// state registers
	// ------------------------------------------------------------
	trxsc_pkg::trxsc_state_t state_q;
	trxsc_pkg::trxsc_state_t state_d;
	trxsc_pkg::trxsc_state_t target_q;
	trxsc_pkg::trxsc_state_t target_d;
	logic [5:0]              cnt_q;
	logic [5:0]              cnt_d;
	logic                    pend_d;
	logic                    wake_d;
	logic                    abort_d;
	logic                    leavePon;
	logic                    clkRise;
	logic                    fastClk;
	logic                    clkEn;
	logic                    wakeIrqEn_q;
	logic                    digOverride_q;
	logic                    cfgWr;

	assign fastClk = (clockOutSelect != `TRXSC_CLKSEL_OFF) && (clockOutSelect < `TRXSC_CLKSEL_SLOW);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		state_d  = state_q;
		target_d = target_q;
		cnt_d    = cnt_q;
		pend_d   = idlePending;
		wake_d   = 1'b0;
		abort_d  = 1'b0;
		if (pinRst) begin
			// a reset held in power-on keeps power-on
			if (state_q != trxsc_pkg::ST_POWER_ON) begin
				state_d = trxsc_pkg::ST_PIN_RESET; // RL6
			end
			pend_d = 1'b0;
		end else begin
			case (state_q)
				trxsc_pkg::ST_POWER_ON: begin
					if (anyIdle) begin
						state_d = trxsc_pkg::ST_IDLE; // RL19
						wake_d  = 1'b1;
					end
				end
				trxsc_pkg::ST_PIN_RESET: begin
					state_d = trxsc_pkg::ST_IDLE; // RL24
					wake_d  = 1'b1;
				end
				trxsc_pkg::ST_IDLE: begin
					if (sleepPin) begin
						// level sensitive: a pin still high after wake re-enters
						target_d = trxsc_pkg::ST_SLEEP; // RL20
						cnt_d    = 6'h00;
						state_d  = fastClk ? trxsc_pkg::ST_CLK_STOP
						                   : trxsc_pkg::ST_SLEEP; // RL22
					end else if (cmdSynth || cmdForceSynth) begin
						target_d = trxsc_pkg::ST_SYNTH;
						cnt_d    = 6'(SETTLE_CYC);
						state_d  = trxsc_pkg::ST_TRANSIT;
					end else if (cmdListen) begin
						target_d = trxsc_pkg::ST_LISTEN;
						cnt_d    = 6'(SETTLE_CYC);
						state_d  = trxsc_pkg::ST_TRANSIT;
					end
				end
				trxsc_pkg::ST_TRANSIT: begin
					// commands are not taken while the pending code shows
					cnt_d = cnt_q - 6'h01; // RL2
					if (cnt_q <= 6'h01) begin
						state_d = target_q;
					end
				end
				trxsc_pkg::ST_SYNTH: begin
					if (anyIdle) begin
						state_d = trxsc_pkg::ST_IDLE; // RL7
					end else if (cmdListen) begin
						state_d = trxsc_pkg::ST_LISTEN;
					end else if (cmdTx) begin
						state_d = trxsc_pkg::ST_BUSY_TX;
					end
				end
				trxsc_pkg::ST_LISTEN: begin
					if (sleepPin) begin
						target_d = trxsc_pkg::ST_NOCLK; // RL4
						cnt_d    = 6'h00;
						state_d  = fastClk ? trxsc_pkg::ST_CLK_STOP
						                   : trxsc_pkg::ST_NOCLK;
					end else if (anyIdle) begin
						state_d = trxsc_pkg::ST_IDLE; // RL7
					end else if (cmdSynth || cmdForceSynth) begin
						state_d = trxsc_pkg::ST_SYNTH; // RL9
					end else if (frameDetect) begin
						state_d = trxsc_pkg::ST_BUSY_RX;
					end
				end
				trxsc_pkg::ST_NOCLK: begin
					// forced synth ready has no effect here
					if (!sleepPin) begin
						state_d = trxsc_pkg::ST_LISTEN; // RL5
					end else if (anyIdle) begin
						state_d = trxsc_pkg::ST_IDLE; // RL7
					end else if (frameDetect) begin
						state_d = trxsc_pkg::ST_BUSY_RX; // RL10
					end
				end
				trxsc_pkg::ST_BUSY_RX, trxsc_pkg::ST_BUSY_TX: begin
					if (cmdForceIdle) begin
						state_d = trxsc_pkg::ST_IDLE; // RL7
						abort_d = 1'b1;
						pend_d  = 1'b0;
					end else if (cmdForceSynth) begin
						state_d = trxsc_pkg::ST_SYNTH; // RL9
						abort_d = 1'b1;
						pend_d  = 1'b0;
					end else if (activityDone) begin
						pend_d = 1'b0;
						if (idlePending || cmdIdle) begin
							state_d = trxsc_pkg::ST_IDLE; // RL8
						end else if (state_q == trxsc_pkg::ST_BUSY_RX) begin
							state_d = trxsc_pkg::ST_LISTEN;
						end else begin
							state_d = trxsc_pkg::ST_SYNTH;
						end
					end else if (cmdIdle) begin
						pend_d = 1'b1; // RL8
					end
				end
				trxsc_pkg::ST_CLK_STOP: begin
					// counts clock output rising edges before stopping it
					if (clkRise) begin
						cnt_d = cnt_q + 6'h01;
						if (cnt_q + 6'h01 >= `TRXSC_STOP_EDGES) begin
							state_d = target_q; // RL21
						end
					end
				end
				trxsc_pkg::ST_SLEEP: begin
					if (!sleepPin) begin
						state_d = trxsc_pkg::ST_IDLE; // RL23
						wake_d  = 1'b1;
					end
				end
				default: begin
					state_d = trxsc_pkg::ST_POWER_ON;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_q     <= trxsc_pkg::ST_POWER_ON; // RL12
			target_q    <= trxsc_pkg::ST_IDLE;
			cnt_q       <= 6'h00;
			idlePending <= 1'b0;
		end else begin
			state_q     <= state_d; // RL1
			target_q    <= target_d;
			cnt_q       <= cnt_d;
			idlePending <= pend_d;
		end
	end

	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------
	assign cfgWr    = cfgReq.wr && pwrCtl.spiEnable;
	assign leavePon = (state_q == trxsc_pkg::ST_POWER_ON) && (state_d == trxsc_pkg::ST_IDLE);

	// clock select is shadowed: only the power-on reset clears it
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			clockOutSelect <= `TRXSC_CLKSEL_RESET; // RL13
		end else if (cfgWr && !pinRst) begin
			clockOutSelect <= cfgReq.clkSel; // RL6
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wakeIrqEn_q   <= 1'b0; // RL17
			digOverride_q <= 1'b0;
		end else if (pinRst) begin
			wakeIrqEn_q   <= 1'b0; // RL6
			digOverride_q <= 1'b0;
		end else if (cfgWr) begin
			wakeIrqEn_q   <= cfgReq.wakeIrqEn;
			digOverride_q <= cfgReq.digOverride;
		end
	end

	// pulls are left alone by the reset pin
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			inputPullEn    <= 1'b1; // RL14
			digOutPullDgnd <= 2'h0;
			digOutPullAgnd <= 2'h0;
		end else if (leavePon) begin
			inputPullEn    <= 1'b0; // RL14
			digOutPullDgnd <= digOverride_q ? 2'h0 : 2'h3; // RL15
			digOutPullAgnd <= digOverride_q ? 2'h0 : 2'h3; // RL15
		end
	end

	// ------------------------------------------------------------
	// events and status
	// ------------------------------------------------------------
	logic [4:0] status_d;
	logic       sleepEnter;

	assign sleepEnter = (state_q != trxsc_pkg::ST_SLEEP) && (state_d == trxsc_pkg::ST_SLEEP);

	always_comb begin
		case (state_d)
			trxsc_pkg::ST_POWER_ON: status_d = `TRXSC_ST_POWER_ON;
			trxsc_pkg::ST_SLEEP:    status_d = `TRXSC_ST_SLEEP;
			trxsc_pkg::ST_IDLE:     status_d = `TRXSC_ST_IDLE;
			trxsc_pkg::ST_SYNTH:    status_d = `TRXSC_ST_SYNTH;
			trxsc_pkg::ST_LISTEN:   status_d = `TRXSC_ST_LISTEN;
			trxsc_pkg::ST_NOCLK:    status_d = `TRXSC_ST_NOCLK;
			trxsc_pkg::ST_BUSY_RX:  status_d = `TRXSC_ST_BUSY_RX;
			trxsc_pkg::ST_BUSY_TX:  status_d = `TRXSC_ST_BUSY_TX;
			default:                status_d = `TRXSC_ST_PENDING; // RL2
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			stateStatus   <= `TRXSC_ST_POWER_ON;
			wakeDoneIrq   <= 1'b0;
			abortActivity <= 1'b0;
			frameBufClear <= 1'b0;
		end else begin
			stateStatus   <= status_d; // RL25
			wakeDoneIrq   <= wake_d && wakeIrqEn_q && !pinRst; // RL19
			abortActivity <= abort_d;
			frameBufClear <= sleepEnter; // RL23
		end
	end

	// ------------------------------------------------------------
	// clock output and power
	// ------------------------------------------------------------
	assign clkEn = xtalOk && (clockOutSelect != `TRXSC_CLKSEL_OFF)
	            && (state_q != trxsc_pkg::ST_SLEEP) && (state_q != trxsc_pkg::ST_NOCLK); // RL22

	trxsc_clkout_gen #(
		.SYMBOL_HZ (SYMBOL_HZ)
	) u_clkout (
		.clk       (clk),
		.nrst      (nrst),
		.enable    (clkEn),
		.sel       (clockOutSelect),
		.clkOut    (clockOut),
		.risePulse (clkRise)
	);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pwrCtl <= '{synthOn: 1'b0, analogRegOn: 1'b0, digitalRegOn: 1'b1,
			            lowPowerRegOn: 1'b0, spiEnable: 1'b1}; // RL12
		end else begin
			pwrCtl.synthOn       <= (state_d >= trxsc_pkg::ST_SYNTH)
			                     && (state_d != trxsc_pkg::ST_CLK_STOP); // RL9
			pwrCtl.analogRegOn   <= (state_d >= trxsc_pkg::ST_TRANSIT)
			                     && (state_d != trxsc_pkg::ST_CLK_STOP);
			pwrCtl.digitalRegOn  <= (state_d != trxsc_pkg::ST_SLEEP);
			pwrCtl.lowPowerRegOn <= (state_d == trxsc_pkg::ST_SLEEP); // RL20
			pwrCtl.spiEnable     <= (state_d != trxsc_pkg::ST_SLEEP);
		end
	end

endmodule : trxsc_state_ctrl

`default_nettype wire

// file: core/trxsc_params.svh
// named offsets, codes and timing figures of the transceiver state control
`ifndef TRXSC_PARAMS_SVH
`define TRXSC_PARAMS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define TRXSC_OFS_STATUS      8'h01
`define TRXSC_OFS_COMMAND     8'h02

// ----------------------------------------------------------------
// state command field codes
// ----------------------------------------------------------------
`define TRXSC_CMD_NOP         5'h00
`define TRXSC_CMD_TX_START    5'h02
`define TRXSC_CMD_FORCE_IDLE  5'h03
`define TRXSC_CMD_FORCE_SYNTH 5'h04
`define TRXSC_CMD_LISTEN      5'h06
`define TRXSC_CMD_IDLE        5'h08
`define TRXSC_CMD_SYNTH       5'h09

// ----------------------------------------------------------------
// state status field codes
// ----------------------------------------------------------------
`define TRXSC_ST_POWER_ON     5'h00
`define TRXSC_ST_BUSY_RX      5'h01
`define TRXSC_ST_BUSY_TX      5'h02
`define TRXSC_ST_LISTEN       5'h06
`define TRXSC_ST_IDLE         5'h08
`define TRXSC_ST_SYNTH        5'h09
`define TRXSC_ST_SLEEP        5'h0f
`define TRXSC_ST_NOCLK        5'h1c
`define TRXSC_ST_PENDING      5'h1f

// ----------------------------------------------------------------
// clock output select and timing
// ----------------------------------------------------------------
`define TRXSC_CLKSEL_OFF      3'h0
`define TRXSC_CLKSEL_RESET    3'h1
`define TRXSC_CLKSEL_SLOW     3'h6
`define TRXSC_STOP_EDGES      6'h23
`define TRXSC_CLK_HZ          125000000
`define TRXSC_CLK_NS          8
`define TRXSC_SETTLE_NS       110
`define TRXSC_CLKOUT1_HZ      1000000
`define TRXSC_CLKOUT2_HZ      2000000
`define TRXSC_CLKOUT3_HZ      4000000
`define TRXSC_CLKOUT4_HZ      8000000
`define TRXSC_CLKOUT5_HZ      16000000
`define TRXSC_CLKOUT6_HZ      250000
`define TRXSC_SYMBOL_HZ       50000

`endif

// file: core/trxsc_pkg.sv
// types shared by the transceiver state control files
`default_nettype none

package trxsc_pkg;

	typedef enum logic [3:0] {
		ST_POWER_ON,
		ST_PIN_RESET,
		ST_SLEEP,
		ST_IDLE,
		ST_TRANSIT,
		ST_SYNTH,
		ST_LISTEN,
		ST_NOCLK,
		ST_BUSY_RX,
		ST_BUSY_TX,
		ST_CLK_STOP
	} trxsc_state_t;

	typedef struct packed {
		logic       valid;
		logic [4:0] code;
	} trxsc_cmd_t;

	typedef struct packed {
		logic       wr;
		logic [2:0] clkSel;
		logic       wakeIrqEn;
		logic       digOverride;
	} trxsc_cfg_t;

	typedef struct packed {
		logic synthOn;
		logic analogRegOn;
		logic digitalRegOn;
		logic lowPowerRegOn;
		logic spiEnable;
	} trxsc_pwr_t;

endpackage : trxsc_pkg

`default_nettype wire

// file: core/trxsc_clkout_gen.sv
// clock output divider with a pulse on every output rising edge
`include "trxsc_params.svh"
`timescale 1ns/1ps
`default_nettype none

module trxsc_clkout_gen #(
	parameter int unsigned SYMBOL_HZ = `TRXSC_SYMBOL_HZ
) (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       nrst,
	// control
	input  wire logic       enable,
	input  wire logic [2:0] sel,
	// output
	output var  logic       clkOut,
	output var  logic       risePulse
);

	localparam int unsigned H1 = `TRXSC_CLK_HZ / (2 * `TRXSC_CLKOUT1_HZ);
	localparam int unsigned H2 = `TRXSC_CLK_HZ / (2 * `TRXSC_CLKOUT2_HZ);
	localparam int unsigned H3 = `TRXSC_CLK_HZ / (2 * `TRXSC_CLKOUT3_HZ);
	localparam int unsigned H4 = `TRXSC_CLK_HZ / (2 * `TRXSC_CLKOUT4_HZ);
	localparam int unsigned H5 = `TRXSC_CLK_HZ / (2 * `TRXSC_CLKOUT5_HZ);
	localparam int unsigned H6 = `TRXSC_CLK_HZ / (2 * `TRXSC_CLKOUT6_HZ);
	localparam int unsigned H7 = `TRXSC_CLK_HZ / (2 * SYMBOL_HZ);

	logic [15:0] halfCnt;
	logic [15:0] cnt_q;
	logic [15:0] cnt_d;
	logic        clk_d;
	logic        wrap;

	// half period per select, in system clocks
	always_comb begin
		case (sel)
			3'h1:    halfCnt = 16'(H1);
			3'h2:    halfCnt = 16'(H2);
			3'h3:    halfCnt = 16'(H3);
			3'h4:    halfCnt = 16'(H4);
			3'h5:    halfCnt = 16'(H5);
			3'h6:    halfCnt = 16'(H6);
			3'h7:    halfCnt = 16'(H7);
			default: halfCnt = 16'h0001;
		endcase
	end

	assign wrap      = enable && (cnt_q + 16'h0001 >= halfCnt);
	assign cnt_d     = (!enable || wrap) ? 16'h0000 : cnt_q + 16'h0001;
	assign clk_d     = enable && (wrap ? !clkOut : clkOut);
	assign risePulse = wrap && !clkOut;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_q  <= 16'h0000;
			clkOut <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			clkOut <= clk_d;
		end
	end

endmodule : trxsc_clkout_gen

`default_nettype wire

// file: tb/trxsc_state_checker.sv
// assertions on the ports of the transceiver state control
`include "trxsc_params.svh"
`timescale 1ns/1ps
`default_nettype none

module trxsc_state_checker (
	// clock and reset
	input wire logic                  clk,
	input wire logic                  nrst,
	// inputs
	input wire logic                  sleepTxPin,
	input wire logic                  resetPinN,
	input wire trxsc_pkg::trxsc_cmd_t cmdReq,
	input wire logic                  frameDetect,
	input wire logic                  activityDone,
	// outputs
	input wire logic [4:0]            stateStatus,
	input wire logic                  abortActivity,
	input wire logic                  idlePending,
	input wire logic                  clockOut,
	input wire logic                  inputPullEn,
	input wire trxsc_pkg::trxsc_pwr_t pwrCtl
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	wire logic       busy = stateStatus == `TRXSC_ST_BUSY_RX || stateStatus == `TRXSC_ST_BUSY_TX;
	wire logic [4:0] code = cmdReq.valid ? cmdReq.code : `TRXSC_CMD_NOP;
	wire logic       pend = stateStatus == `TRXSC_ST_PENDING;
	logic [7:0]      riseCnt_q;
	logic [7:0]      riseCnt_d;
	logic            clkOut_q;

	// clock output rises seen while the stop wait shows pending
	assign riseCnt_d = pend ? riseCnt_q + {7'h00, clockOut & ~clkOut_q} : 8'h00;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			riseCnt_q <= 8'h00;
			clkOut_q  <= 1'b0;
		end else begin
			riseCnt_q <= riseCnt_d;
			clkOut_q  <= clockOut;
		end
	end

	sequence s_noclkLow;
		$fell(sleepTxPin) && stateStatus == `TRXSC_ST_NOCLK
			##1 (!sleepTxPin && !frameDetect && resetPinN)[*5];
	endsequence
	sequence s_sleepLow;
		$fell(sleepTxPin) && stateStatus == `TRXSC_ST_SLEEP ##1 (!sleepTxPin && resetPinN)[*6];
	endsequence

	property p_pendIdle;
		busy && code == `TRXSC_CMD_IDLE && !activityDone && resetPinN
			|=> idlePending && $stable(stateStatus);
	endproperty
	property p_forceIdle;
		busy && code == `TRXSC_CMD_FORCE_IDLE |=> stateStatus == `TRXSC_ST_IDLE && abortActivity;
	endproperty
	property p_forceSynth;
		busy && code == `TRXSC_CMD_FORCE_SYNTH
			|=> stateStatus == `TRXSC_ST_SYNTH && abortActivity && pwrCtl.synthOn;
	endproperty
	property p_synthIgnored;
		code == `TRXSC_CMD_FORCE_SYNTH && (stateStatus == `TRXSC_ST_POWER_ON
			|| stateStatus == `TRXSC_ST_NOCLK || stateStatus == `TRXSC_ST_SLEEP)
			|=> stateStatus != `TRXSC_ST_SYNTH;
	endproperty
	property p_clkStop;
		(stateStatus == `TRXSC_ST_SLEEP || stateStatus == `TRXSC_ST_NOCLK) && $past(pend)
			|-> riseCnt_q >= 8'h22 && riseCnt_q <= 8'h24;
	endproperty
	property p_noclkReturn;
		s_noclkLow |-> stateStatus == `TRXSC_ST_LISTEN;
	endproperty
	property p_wake;
		s_sleepLow |-> stateStatus == `TRXSC_ST_IDLE;
	endproperty
	property p_powerOn;
		stateStatus == `TRXSC_ST_POWER_ON
			|-> inputPullEn && pwrCtl.spiEnable && pwrCtl.digitalRegOn && !pwrCtl.lowPowerRegOn;
	endproperty

	a_pendIdle: assert property (p_pendIdle) else $error("idle not held during busy");
	a_forceIdle: assert property (p_forceIdle) else $error("forced idle missed");
	a_forceSynth: assert property (p_forceSynth) else $error("forced synth missed");
	a_synthIgnored: assert property (p_synthIgnored) else $error("forced synth taken");
	a_clkStop: assert property (p_clkStop) else $error("clock stop count wrong");
	a_noclkReturn: assert property (p_noclkReturn) else $error("no return to listen");
	a_wake: assert property (p_wake) else $error("no wake from sleep");
	a_powerOn: assert property (p_powerOn) else $error("power-on settings wrong");
endmodule : trxsc_state_checker

bind trxsc_state_ctrl trxsc_state_checker u_chk (
	.clk, .nrst, .sleepTxPin, .resetPinN, .cmdReq, .frameDetect, .activityDone,
	.stateStatus, .abortActivity, .idlePending, .clockOut, .inputPullEn, .pwrCtl
);

`default_nettype wire

// file: tb/trxsc_host_model.sv
// host side model: pins, command writes and configuration writes
`include "trxsc_params.svh"
`timescale 1ns/1ps
`default_nettype none

module trxsc_host_model (
	// clock
	input  wire logic                  clk,
	// device status
	input  wire logic [4:0]            stateStatus,
	input  wire logic                  clockOut,
	// pins and writes
	output var  logic                  sleepTxPin,
	output var  logic                  resetPinN,
	output var  trxsc_pkg::trxsc_cmd_t cmdReq,
	output var  trxsc_pkg::trxsc_cfg_t cfgReq,
	output var  logic                  stuck
);
	logic linkClk = 1'b0;

	// pin changes come from an unrelated 64 ns grid
	always #32 linkClk = ~linkClk;

	initial begin
		sleepTxPin = 1'b0;
		resetPinN  = 1'b1;
		cmdReq     = '0;
		cfgReq     = '0;
		stuck      = 1'b0;
	end

	task automatic set_pin(input logic v);
		@(posedge linkClk);
		#1 sleepTxPin = v;
	endtask : set_pin

	task automatic wait_clkout();
		int n;
		n = 0;
		while (clockOut !== 1'b1 && n < 500) begin
			@(posedge clk);
			n++;
		end
		if (n == 500) stuck = 1'b1;
	endtask : wait_clkout

	task automatic send_cmd(input logic [4:0] c);
		int n;
		n = 0;
		if (c == `TRXSC_CMD_FORCE_IDLE || c == `TRXSC_CMD_FORCE_SYNTH) sleepTxPin = 1'b0;
		while (stateStatus === `TRXSC_ST_PENDING && n < 100) begin
			@(posedge clk);
			n++;
		end
		if (n == 100) stuck = 1'b1;
		@(posedge clk);
		#1 cmdReq = '{valid: 1'b1, code: c};
		@(posedge clk);
		#1 cmdReq.valid = 1'b0;
	endtask : send_cmd

	task automatic write_cfg(input logic [2:0] s, input logic irq, input logic ovr);
		@(posedge clk);
		#1 cfgReq = '{wr: 1'b1, clkSel: s, wakeIrqEn: irq, digOverride: ovr};
		@(posedge clk);
		#1 cfgReq.wr = 1'b0;
	endtask : write_cfg

	task automatic pulse_reset();
		@(posedge clk);
		#1 sleepTxPin = 1'b0;
		resetPinN = 1'b0;
		repeat (8) @(posedge clk);
		#1 resetPinN = 1'b1;
	endtask : pulse_reset
endmodule : trxsc_host_model

`default_nettype wire

// file: tb/tb.sv
// self-checking bench of the transceiver state control
`include "trxsc_params.svh"
`timescale 1ns/1ps
`default_nettype none

module tb;
	logic                  clk = 1'b0, nrst = 1'b0, xtalStable = 1'b0;
	logic                  frameDetect = 1'b0, activityDone = 1'b0;
	logic                  sleepTxPin, resetPinN, stuck;
	logic [4:0]            stateStatus;
	logic [2:0]            clockOutSelect;
	logic                  wakeDoneIrq, abortActivity, frameBufClear;
	logic                  idlePending, clockOut, inputPullEn;
	logic [1:0]            digOutPullDgnd, digOutPullAgnd;
	trxsc_pkg::trxsc_cmd_t cmdReq;
	trxsc_pkg::trxsc_cfg_t cfgReq;
	trxsc_pkg::trxsc_pwr_t pwrCtl;
	int                    failures = 0, compares = 0;
	int                    wakeSeen = 0, abortSeen = 0, clearSeen = 0;
	logic [2:0]            sels [3] = '{3'h0, 3'h6, 3'h7};

	always #4 clk = ~clk;

	// event pulses are counted mid-cycle, where they are settled
	always @(negedge clk) begin
		if (wakeDoneIrq === 1'b1) wakeSeen++;
		if (abortActivity === 1'b1) abortSeen++;
		if (frameBufClear === 1'b1) clearSeen++;
	end

	trxsc_state_ctrl u_dut (
		.clk, .nrst, .sleepTxPin, .resetPinN, .xtalStable, .cmdReq, .cfgReq, .frameDetect,
		.activityDone, .stateStatus, .clockOutSelect, .wakeDoneIrq, .abortActivity,
		.frameBufClear, .idlePending, .clockOut, .inputPullEn, .digOutPullDgnd,
		.digOutPullAgnd, .pwrCtl
	);
	trxsc_host_model u_host (
		.clk, .stateStatus, .clockOut, .sleepTxPin, .resetPinN, .cmdReq, .cfgReq, .stuck
	);

	task automatic final_report();
		if (stuck !== 1'b0) failures++;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : final_report

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : settle

	task automatic wait_st(input logic [4:0] exp, input int bound);
		int n;
		n = 0;
		while (stateStatus !== exp && n < bound) begin
			@(posedge clk);
			#1 n++;
		end
		check("stateStatus", stateStatus, exp);
		if (stateStatus !== exp) final_report();
		settle(1);
	endtask : wait_st

	task automatic pulse(input logic rx);
		@(posedge clk);
		#1 frameDetect = rx;
		activityDone = !rx;
		@(posedge clk);
		#1 frameDetect = 1'b0;
		activityDone = 1'b0;
	endtask : pulse

	task automatic to_synth();
		u_host.send_cmd(`TRXSC_CMD_SYNTH);
		wait_st(`TRXSC_ST_SYNTH, 100);
	endtask : to_synth

	initial begin
		settle(4);
		nrst = 1'b1;
		check("status", stateStatus, `TRXSC_ST_POWER_ON);
		check("clkSel", clockOutSelect, `TRXSC_CLKSEL_RESET);
		check("pullEn", inputPullEn, 1'b1);
		check("pwrCtl", pwrCtl, 5'h05);
		xtalStable = 1'b1;
		u_host.wait_clkout();
		u_host.pulse_reset();
		settle(6);
		check("status", stateStatus, `TRXSC_ST_POWER_ON);
		check("pullEn", inputPullEn, 1'b1);
		u_host.send_cmd(`TRXSC_CMD_FORCE_SYNTH);
		settle(4);
		check("status", stateStatus, `TRXSC_ST_POWER_ON);
		u_host.write_cfg(3'h1, 1'b1, 1'b0);
		u_host.send_cmd(`TRXSC_CMD_IDLE);
		wait_st(`TRXSC_ST_IDLE, 100);
		check("pullEn", inputPullEn, 1'b0);
		check("digPulls", {digOutPullDgnd, digOutPullAgnd}, 4'hf);
		check("wake", wakeSeen, 32'h1);
		u_host.send_cmd(`TRXSC_CMD_TX_START);
		settle(4);
		check("status", stateStatus, `TRXSC_ST_IDLE);
		to_synth();
		check("synthOn", pwrCtl.synthOn, 1'b1);
		u_host.send_cmd(`TRXSC_CMD_TX_START);
		wait_st(`TRXSC_ST_BUSY_TX, 10);
		u_host.send_cmd(`TRXSC_CMD_IDLE);
		settle(2);
		check("idlePending", idlePending, 1'b1);
		check("status", stateStatus, `TRXSC_ST_BUSY_TX);
		pulse(1'b0);
		wait_st(`TRXSC_ST_IDLE, 10);
		to_synth();
		u_host.send_cmd(`TRXSC_CMD_TX_START);
		wait_st(`TRXSC_ST_BUSY_TX, 10);
		u_host.send_cmd(`TRXSC_CMD_FORCE_IDLE);
		wait_st(`TRXSC_ST_IDLE, 4);
		to_synth();
		u_host.send_cmd(`TRXSC_CMD_LISTEN);
		wait_st(`TRXSC_ST_LISTEN, 100);
		pulse(1'b1);
		wait_st(`TRXSC_ST_BUSY_RX, 10);
		u_host.send_cmd(`TRXSC_CMD_FORCE_SYNTH);
		wait_st(`TRXSC_ST_SYNTH, 4);
		check("aborts", abortSeen, 32'h2);
		u_host.send_cmd(`TRXSC_CMD_LISTEN);
		wait_st(`TRXSC_ST_LISTEN, 100);
		u_host.set_pin(1'b1);
		wait_st(`TRXSC_ST_NOCLK, 5000);
		u_host.set_pin(1'b0);
		wait_st(`TRXSC_ST_LISTEN, 20);
		u_host.send_cmd(`TRXSC_CMD_FORCE_IDLE);
		wait_st(`TRXSC_ST_IDLE, 100);
		u_host.set_pin(1'b1);
		wait_st(`TRXSC_ST_SLEEP, 5000);
		check("bufClear", clearSeen, 32'h1);
		u_host.set_pin(1'b0);
		wait_st(`TRXSC_ST_IDLE, 20);
		check("wake", wakeSeen, 32'h2);
		check("clkSel", clockOutSelect, 3'h1);
		for (int s = 0; s < 3; s++) begin
			u_host.write_cfg(sels[s], 1'b0, 1'b0);
			u_host.set_pin(1'b1);
			wait_st(`TRXSC_ST_SLEEP, 10);
			u_host.set_pin(1'b0);
			wait_st(`TRXSC_ST_IDLE, 20);
		end
		u_host.set_pin(1'b1);
		wait_st(`TRXSC_ST_SLEEP, 10);
		u_host.pulse_reset();
		wait_st(`TRXSC_ST_IDLE, 30);
		check("clkSel", clockOutSelect, 3'h7);
		check("wake", wakeSeen, 32'h2);
		nrst = 1'b0;
		settle(2);
		nrst = 1'b1;
		check("clkSel", clockOutSelect, `TRXSC_CLKSEL_RESET);
		u_host.write_cfg(3'h1, 1'b0, 1'b1);
		u_host.send_cmd(`TRXSC_CMD_FORCE_IDLE);
		wait_st(`TRXSC_ST_IDLE, 100);
		check("digPulls", {digOutPullDgnd, digOutPullAgnd}, 4'h0);
		final_report();
	end
endmodule : tb

`default_nettype wire
